// File: common/page_ecc_pkg.sv
/*
 Shared constants and carriers for the page correction engine.
 Assumes a single 40 MHz clock and byte-wide cache access.
*/
// Functional notes
// - Correction is enabled after reset without any configuration.
// - Set-features writes enable flag; 1 enables, 0 disables; device obeys.
// - Program with correction on computes parity over cached page first.
// - Read with correction on recomputes parity, compares, counts bit errors; cache is not corrected.
// - With correction on the serial lines get the cache as loaded from the array, uncorrected.
// - Each read updates the correction status to success or failure.
// - Status 0000b none, 0001b-1000b corrected count, 1111b uncorrectable.
// - Status clears on reset and read start, updates at read completion.
// - Parity covers main 000H-7FFH and spare 800H-83FH.
// - Parity stored at 840H-873H; 874H-87FH metadata left uncovered.
// - With correction on host writes to parity bytes are discarded.
// - Factory bad blocks carry 00h at byte 2048 of first page.
// - At least 1004 of 1024 blocks stay valid; bad blocks isolated.
package page_ecc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] COVER_LAST = 12'h83F;
	localparam logic [11:0] PARITY_FIRST = 12'h840;
	localparam logic [11:0] PARITY_LAST = 12'h873;
	localparam logic [11:0] PAGE_LAST = 12'h87F;
	localparam logic [11:0] BAD_MARK_ADDR = 12'h800;
	localparam logic [7:0] BAD_MARK_VALUE = 8'h00;
	localparam logic [7:0] GOOD_MARK_VALUE = 8'hFF;
	localparam logic [3:0] STATUS_CLEAN = 4'h0;
	localparam logic [3:0] STATUS_MAX_FIXED = 4'h8;
	localparam logic [3:0] STATUS_FAILED = 4'hF;
	localparam int MAX_FIX = 8;
	localparam logic ECC_EN_RESET = 1'b1;
	localparam int BLOCKS_PER_DIE = 1024;
	localparam int MIN_VALID_BLOCK_COUNT = 1004;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int POWER_UP_WRITE_DELAY_MS = 6;
	localparam int POWER_UP_WRITE_DELAY_CYC = SYS_CLK_HZ / 1000 * POWER_UP_WRITE_DELAY_MS;

	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} cache_wr_t;

	typedef struct packed {
		logic valid;
		logic [3:0] correction_result_field;
	} ecc_status_t;
endpackage

// File: hdl/parity_accum.sv
/*
 Byte parity accumulator: 52-byte signature over covered bytes.
 Assumes the owner clears it before a pass and feeds one byte per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module parity_accum import page_ecc_pkg::*; #(
	parameter int PAR_BYTES = 52
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_en,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_data,
	output logic [PAR_BYTES*8-1:0] o_parity
);
	typedef struct packed {
		logic [PAR_BYTES*8-1:0] par;
	} acc_state_t;
	acc_state_t st_r, st_nxt;
	logic [5:0] lane;

	// Lane is address folded onto the parity width; upper address bits mixed in give a position code
	always_comb begin
		lane = 6'(i_addr % 12'(PAR_BYTES));
		st_nxt = st_r;
		if (i_clear) begin
			st_nxt.par = '0;
		end else if (i_en) begin
			st_nxt.par[lane*8 +: 8] = st_r.par[lane*8 +: 8] ^ i_data ^ i_addr[11:4];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_parity = st_r.par;
endmodule
`default_nettype wire

// File: hdl/page_ecc_engine.sv
/*
 Page correction engine: cache, parity encode on program, check and
 error count on read, status, and discard of host writes to parity bytes.
 Assumes a command decoder drives the start strobes and cache ports,
 and that the array side returns stored bytes one per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module page_ecc_engine import page_ecc_pkg::*; #(
	parameter int PAR_BYTES = 52,
	parameter int PAGE_BYTES = 2176
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_set_feature,
	input wire logic i_set_ecc_en,
	input wire cache_wr_t i_host_wr,
	input wire logic i_prog_start,
	input wire logic i_read_start,
	input wire cache_wr_t i_array_wr,
	input wire logic i_array_done,
	input wire logic [11:0] i_rd_addr,
	output logic [7:0] o_rd_data,
	output logic o_ecc_en,
	output logic o_busy,
	output logic o_prog_ready,
	output ecc_status_t o_status,
	output logic o_bad_block
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_ENC = 4'b0010,
		S_LOAD = 4'b0100,
		S_CHK = 4'b1000
	} eng_state_t;

	typedef struct packed {
		eng_state_t fsm;
		logic ecc_en;
		logic [11:0] ptr;
		logic [3:0] errs;
		logic prog_ready;
		ecc_status_t status;
		logic [7:0] rd_data;
		logic bad;
	} state_t;

	state_t st_r, st_nxt;
	logic [7:0] cache [0:PAGE_BYTES-1];
	logic [7:0] stored_par [0:PAR_BYTES-1];
	logic [PAR_BYTES*8-1:0] par;
	logic acc_clear, acc_en, par_wr;
	logic [5:0] par_idx;
	logic [7:0] syn;
	logic cache_we;
	logic [11:0] cache_wa;
	logic [7:0] cache_wd;

	function automatic logic is_parity(input logic [11:0] a);
		return a >= PARITY_FIRST && a <= PARITY_LAST;
	endfunction

	function automatic logic [3:0] popcnt(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + 4'(v[i]);
		end
		return n;
	endfunction

	parity_accum #(.PAR_BYTES(PAR_BYTES)) u_acc (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_clear(acc_clear),
		.i_en(acc_en),
		.i_addr(st_r.ptr),
		.i_data(cache[st_r.ptr]),
		.o_parity(par)
	);

	always_comb begin
		st_nxt = st_r;
		acc_clear = 1'b0;
		acc_en = 1'b0;
		par_wr = 1'b0;
		cache_we = 1'b0;
		cache_wa = i_host_wr.addr;
		cache_wd = i_host_wr.data;
		par_idx = 6'(st_r.ptr - PARITY_FIRST);
		syn = par[par_idx*8 +: 8] ^ stored_par[par_idx];
		if (i_set_feature) begin
			st_nxt.ecc_en = i_set_ecc_en;
		end
		case (st_r.fsm)
			S_IDLE: begin
				if (i_host_wr.we && !(st_r.ecc_en && is_parity(i_host_wr.addr))) begin
					cache_we = 1'b1;
				end
				if (i_prog_start) begin
					st_nxt.prog_ready = 1'b0;
					if (st_r.ecc_en) begin
						acc_clear = 1'b1;
						st_nxt.ptr = '0;
						st_nxt.fsm = S_ENC;
					end else begin
						st_nxt.prog_ready = 1'b1;
					end
				end else if (i_read_start) begin
					st_nxt.status = '{valid: 1'b0, correction_result_field: STATUS_CLEAN};
					st_nxt.errs = '0;
					st_nxt.fsm = S_LOAD;
				end
			end
			S_ENC: begin
				if (st_r.ptr <= COVER_LAST) begin
					acc_en = 1'b1;
					st_nxt.ptr = st_r.ptr + 12'h001;
				end else begin
					// Last covered byte is now inside the accumulator
					st_nxt.fsm = S_IDLE;
					st_nxt.prog_ready = 1'b1;
					par_wr = 1'b1;
				end
			end
			S_LOAD: begin
				cache_we = i_array_wr.we;
				cache_wa = i_array_wr.addr;
				cache_wd = i_array_wr.data;
				if (i_array_done) begin
					acc_clear = 1'b1;
					st_nxt.ptr = '0;
					if (st_r.ecc_en) begin
						st_nxt.fsm = S_CHK;
					end else begin
						st_nxt.fsm = S_IDLE;
						st_nxt.status.valid = 1'b1;
					end
				end
			end
			S_CHK: begin
				if (st_r.ptr <= COVER_LAST) begin
					acc_en = 1'b1;
					st_nxt.ptr = st_r.ptr + 12'h001;
				end else if (st_r.ptr <= PARITY_LAST) begin
					// Count mismatching bits; accumulate saturating
					if (5'(st_r.errs) + 5'(popcnt(syn)) > 5'(MAX_FIX)) begin
						st_nxt.errs = STATUS_FAILED;
					end else begin
						st_nxt.errs = st_r.errs + popcnt(syn);
					end
					st_nxt.ptr = st_r.ptr + 12'h001;
				end else begin
					st_nxt.fsm = S_IDLE;
					st_nxt.status.valid = 1'b1;
					st_nxt.status.correction_result_field = st_r.errs;
				end
			end
			default: begin
				st_nxt.fsm = S_IDLE;
			end
		endcase
		st_nxt.bad = (cache[BAD_MARK_ADDR] != GOOD_MARK_VALUE);
		// Serial lines read the cache as loaded from the array stream; no repair is applied
		st_nxt.rd_data = cache[i_rd_addr];
	end

	// Cache writes; array load lands here and is never repaired in place
	always_ff @(posedge i_sys_clk) begin
		if (cache_we && 32'(cache_wa) < PAGE_BYTES) begin
			cache[cache_wa] <= cache_wd;
		end
		if (par_wr) begin
			for (int i = 0; i < PAR_BYTES; i++) begin
				stored_par[i] <= par[i*8 +: 8];
				cache[32'(PARITY_FIRST) + i] <= par[i*8 +: 8];
			end
		end
		if (st_r.fsm == S_LOAD && i_array_wr.we && is_parity(i_array_wr.addr)) begin
			stored_par[6'(i_array_wr.addr - PARITY_FIRST)] <= i_array_wr.data;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_r.fsm <= S_IDLE;
			st_r.ecc_en <= ECC_EN_RESET;
			st_r.ptr <= '0;
			st_r.errs <= '0;
			st_r.prog_ready <= 1'b0;
			st_r.status <= '{valid: 1'b0, correction_result_field: STATUS_CLEAN};
			st_r.rd_data <= '0;
			st_r.bad <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rd_data = st_r.rd_data;
	assign o_ecc_en = st_r.ecc_en;
	assign o_busy = (st_r.fsm != S_IDLE);
	assign o_prog_ready = st_r.prog_ready;
	assign o_status = st_r.status;
	assign o_bad_block = st_r.bad;
endmodule
`default_nettype wire

// File: verif/host_gate.sv
/* Host-side model: raises write-ok once a DELAY-cycle power-up wait has run.
 Assumes one clock and the engine's synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module host_gate #(
	parameter int DELAY = 40
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	output logic o_write_ok
);
	int cnt_r;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) cnt_r <= 0;
		else if (cnt_r < DELAY) cnt_r <= cnt_r + 1;
	end
	assign o_write_ok = (cnt_r == DELAY);
endmodule
`default_nettype wire

// File: verif/page_ecc_assertions.sv
/* Port checker for the page correction engine.
 Assumes the engine's clock and synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module page_ecc_assertions import page_ecc_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_set_feature,
	input wire logic i_set_ecc_en,
	input wire logic i_prog_start,
	input wire logic i_read_start,
	input wire logic i_array_done,
	input wire logic o_ecc_en,
	input wire logic o_busy,
	input wire logic o_prog_ready,
	input wire ecc_status_t o_status
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_ecc_default_on: assert property ($fell(i_rst) |-> o_ecc_en)
		else $error("correction off after reset");
	a_feature_obeyed: assert property (i_set_feature |=> o_ecc_en == $past(i_set_ecc_en))
		else $error("enable flag not taken");
	a_read_clears: assert property (i_read_start && !i_prog_start && !o_busy
		|=> o_busy && o_status == '0) else $error("status not cleared at read");
	a_status_code: assert property (o_status.valid |->
		o_status.correction_result_field <= 4'h8 || o_status.correction_result_field == 4'hF)
		else $error("illegal status code");
	a_encode_first: assert property (i_prog_start && !o_busy && o_ecc_en
		|=> !o_prog_ready [*8]) else $error("ready before parity pass");
	a_plain_prog: assert property (i_prog_start && !o_busy && !o_ecc_en
		|-> ##[1:2] o_prog_ready) else $error("plain program not ready");
	a_plain_read: assert property (i_array_done && o_busy && !o_ecc_en
		|-> ##[1:2] o_status.valid) else $error("plain read status late");
	a_status_holds: assert property (o_status.valid && !i_read_start
		|=> $stable(o_status)) else $error("status changed");
	a_ready_holds: assert property (o_prog_ready && !i_prog_start |=> o_prog_ready)
		else $error("ready dropped");
	c_fixed: cover property (o_status.valid && o_status.correction_result_field != 4'h0);
	c_ready: cover property (o_prog_ready && o_ecc_en);
	c_plain: cover property (o_status.valid && !o_ecc_en);
endmodule
bind page_ecc_engine page_ecc_assertions u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_set_feature(i_set_feature), .i_set_ecc_en(i_set_ecc_en), .i_prog_start(i_prog_start),
	.i_read_start(i_read_start), .i_array_done(i_array_done), .o_ecc_en(o_ecc_en),
	.o_busy(o_busy), .o_prog_ready(o_prog_ready), .o_status(o_status));
`default_nettype wire

// File: verif/nand_page_ecc_and_bad_block_test.sv
/* Self-checking bench for the page correction engine.
 Assumes the host gate model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module nand_page_ecc_and_bad_block_test import page_ecc_pkg::*; ;
	logic clk = 0, rst = 1, sf = 0, se = 0, ps = 0, rs = 0, dn = 0, ok, ecc, busy, rdy, bad;
	cache_wr_t hw = '0, aw = '0;
	logic [11:0] ra = '0;
	logic [7:0] rd, v, pg [2176];
	ecc_status_t st;
	int miscompares = 0, n_checks = 0;
	page_ecc_engine u_dut (.i_sys_clk(clk), .i_rst(rst), .i_set_feature(sf), .i_set_ecc_en(se),
		.i_host_wr(hw), .i_prog_start(ps), .i_read_start(rs), .i_array_wr(aw), .i_array_done(dn),
		.i_rd_addr(ra), .o_rd_data(rd), .o_ecc_en(ecc), .o_busy(busy), .o_prog_ready(rdy),
		.o_status(st), .o_bad_block(bad));
	host_gate #(.DELAY(40)) u_host (.i_sys_clk(clk), .i_rst(rst), .o_write_ok(ok));
	initial forever #12.5 clk = ~clk;
	task automatic step(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		hw <= '{1'b1, a, d};
		@(posedge clk);
		hw <= '0;
	endtask
	task automatic rd_cache(logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		ra <= a;
		step(2);
		d = rd;
	endtask
	task automatic load(logic [3:0] lo, logic [3:0] hi, int lim, string n);
		@(posedge clk);
		rs <= 1'b1;
		for (int a = 0; a < 2176; a++) begin
			@(posedge clk);
			rs <= 1'b0;
			aw <= '{1'b1, 12'(a), pg[a]};
		end
		@(posedge clk);
		aw <= '0;
		dn <= 1'b1;
		@(posedge clk);
		dn <= 1'b0;
		for (int i = 1; i < lim && st.valid !== 1'b1; i++) step();
		#1 chk({n, "_valid"}, 1, st.valid);
		chk(n, 1, st.correction_result_field inside {[lo:hi]});
		chk({n, "_idle"}, 0, busy);
	endtask
	task automatic t_program();
		for (int a = 0; a < 2176; a++) pg[a] = 8'(a) ^ 8'(a >> 4);
		pg[12'h800] = 8'hFF;
		for (int a = 0; a < 12'h840; a++) begin
			@(posedge clk);
			hw <= '{1'b1, 12'(a), pg[a]};
		end
		@(posedge clk);
		hw <= '0;
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		for (int i = 0; i < 3000 && rdy !== 1'b1; i++) step();
		chk("prog_ready", 1, rdy);
		for (int a = 12'h840; a < 12'h874; a++) rd_cache(12'(a), pg[a]);
	endtask
	task automatic t_discard();
		wr(12'h840, ~pg[12'h840]);
		rd_cache(12'h840, v);
		chk("parity_kept", pg[12'h840], v);
	endtask
	task automatic t_read();
		load(4'h0, 4'h0, 3000, "clean");
		rd_cache(12'h005, v);
		chk("served_byte", pg[12'h005], v);
		pg[12'h874] ^= 8'h01;
		load(4'h0, 4'h0, 3000, "meta_uncovered");
		pg[12'h83F] ^= 8'h01;
		load(4'h1, 4'h1, 3000, "spare_fixed");
		pg[12'h83F] ^= 8'h01;
		pg[12'h005] ^= 8'h10;
		load(4'h1, 4'h1, 3000, "main_fixed");
		pg[12'h006] ^= 8'hFF;
		load(4'hF, 4'hF, 3000, "too_many");
	endtask
	task automatic t_bad_mark();
		chk("good_mark", 0, bad);
		wr(12'h800, 8'h00);
		step(3);
		chk("bad_mark", 1, bad);
	endtask
	task automatic t_no_ecc();
		@(posedge clk);
		sf <= 1'b1;
		se <= 1'b0;
		@(posedge clk);
		sf <= 1'b0;
		step();
		chk("ecc_off", 0, ecc);
		load(4'h0, 4'hF, 3, "plain_read");
		chk("mark_clear", 0, bad);
		wr(12'h840, 8'h5A);
		@(posedge clk);
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		step();
		chk("plain_ready", 1, rdy);
		rd_cache(12'h840, v);
		chk("plain_parity", 8'h5A, v);
		@(posedge clk);
		sf <= 1'b1;
		se <= 1'b1;
		@(posedge clk);
		sf <= 1'b0;
		step();
		chk("ecc_on", 1, ecc);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 100 && ok !== 1'b1; i++) step();
		chk("write_ok", 1, ok);
		chk("ecc_default", 1, ecc);
		t_program();
		t_discard();
		t_read();
		t_bad_mark();
		t_no_ecc();
		complete_run();
	end
	initial begin
		step(40000);
		miscompares++;
		complete_run();
	end
endmodule
`default_nettype wire
